// file: common/tws_pkg.sv
package tws_pkg;

    // Word and address layout
    localparam int WORD_BITS = 8;
    localparam int ADDR_BITS = 7;
    localparam logic DIR_READ = 1'h1;
    localparam logic ACK_LEVEL = 1'h0;
    localparam logic SDA_RELEASE = 1'h1;

    // Bit timing on the link clock: quarter bit period, least time rounded up
    localparam int BIT_PERIOD_NS = 10000;
    localparam int LINK_CLK_PS = 6000;
    localparam int QUARTER_CYCLES = (BIT_PERIOD_NS * 1000 / 4 + LINK_CLK_PS - 1) / LINK_CLK_PS;

    // Phases of one bit operation
    localparam logic [1:0] PHASE_FIRST = 2'h0;
    localparam logic [1:0] PHASE_SAMPLE = 2'h2;
    localparam logic [1:0] PHASE_LAST = 2'h3;

    // Sizes
    localparam int COUNT_WIDTH = 16;
    localparam int BUF_DEPTH = 2;

    typedef enum logic [1:0] {
        OP_IDLECHK,
        OP_START,
        OP_BIT,
        OP_STOP
    } tws_op_t;

    typedef enum logic [3:0] {
        CS_IDLE,
        CS_FREE,
        CS_START,
        CS_ADDR,
        CS_AACK,
        CS_WLOAD,
        CS_WBIT,
        CS_WACK,
        CS_RWAIT,
        CS_RBIT,
        CS_RACK,
        CS_STOP
    } tws_core_t;

endpackage : tws_pkg

// file: verilog/tws_fifo.sv
`timescale 1ns/1ps

module tws_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W-1:0] rdPtr;
    logic [CNT_W-1:0] count;

    wire push = inValid && inReady;
    wire pop = outValid && outReady;

    assign inReady = count != CNT_FULL;
    assign outValid = count != '0;
    assign outData = mem[rdPtr];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wrPtr <= (wrPtr == PTR_LAST) ? '0 : wrPtr + PTR_W'(1);
            end
            if (pop) begin
                rdPtr <= (rdPtr == PTR_LAST) ? '0 : rdPtr + PTR_W'(1);
            end
            if (push && !pop) begin
                count <= count + CNT_W'(1);
            end else if (pop && !push) begin
                count <= count - CNT_W'(1);
            end
        end
    end

endmodule : tws_fifo

// file: verilog/tws_sequencer.sv
`timescale 1ns/1ps

// Contract
// - Before a transaction the sequencer waits until both data and clock lines are seen high.
// - The sequencer claims the bus with a START; other devices then listen for their address.
// - The sequencer drives the clock line for the whole transaction as the timing reference.
// - The driver of the data line keeps it stable across each rising clock edge.
// - After START the sequencer shifts out the target address serially.
// - Right after the address the sequencer sends one direction bit, read or write.
// - The target acknowledges its address and data only moves after that acknowledge.
// - Data moves in 8-bit words, any number of them, each acknowledged by the receiver; reading, the sequencer answers the last word with no acknowledge.
// - After the last word the sequencer releases the bus with a STOP.

module tws_sequencer
    import tws_pkg::*;
#(
    parameter int QUARTER = QUARTER_CYCLES,
    parameter int COUNT_W = COUNT_WIDTH,
    parameter int DEPTH = BUF_DEPTH
) (
    // System clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Command
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic [ADDR_BITS-1:0] cmdAddr,
    input wire logic cmdRead,
    input wire logic [COUNT_W-1:0] cmdCount,
    // Words to send
    input wire logic wrValid,
    output logic wrReady,
    input wire logic [WORD_BITS-1:0] wrData,
    // Words received
    output logic rdValid,
    input wire logic rdReady,
    output logic [WORD_BITS-1:0] rdData,
    // Status
    output logic busy,
    output logic xferDone,
    output logic xferNack,
    // Two-wire link
    input wire logic linkClk,
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe
);

    localparam int TICK_W = $clog2(QUARTER + 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(QUARTER - 1);
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [COUNT_W-1:0] COUNT_ONE = COUNT_W'(1);

    // Core domain state
    tws_core_t state;
    logic pending;
    logic reqTgl;
    tws_op_t opReq;
    logic bitReq;
    logic [WORD_BITS-1:0] shift;
    logic [2:0] bitCnt;
    logic [COUNT_W-1:0] remain;
    logic readMode;
    logic nackSeen;
    logic ackMeta;
    logic ackSync;
    logic ackSeen;

    // Link domain state
    logic reqMeta;
    logic reqSync;
    logic reqSeen;
    logic running;
    tws_op_t lkOp;
    logic lkBit;
    logic [1:0] phase;
    logic [TICK_W-1:0] tick;
    logic ackTgl;
    logic rxBit;
    logic sclPull;
    logic sdaPull;
    logic sclMeta;
    logic sclSync;
    logic sdaMeta;
    logic sdaSync;

    // Read buffer
    logic bufInReady;

    // Core decode
    wire ackPulse = ackSync ^ ackSeen;
    wire needOp = state != CS_IDLE && state != CS_WLOAD && state != CS_RWAIT;
    wire issueNow = needOp && !pending;
    wire lastBit = bitCnt == '0;
    wire lastWord = remain == COUNT_ONE;
    wire gotAck = rxBit == ACK_LEVEL;
    wire pushWord = ackPulse && state == CS_RBIT && lastBit;
    wire [WORD_BITS-1:0] rxWord = {shift[WORD_BITS-2:0], rxBit};

    // Master answers a read word: acknowledge all but the last
    wire masterAck = lastWord ? SDA_RELEASE : ACK_LEVEL;

    tws_op_t next_op;
    assign next_op = (state == CS_FREE) ? OP_IDLECHK :
                     (state == CS_START) ? OP_START :
                     (state == CS_STOP) ? OP_STOP : OP_BIT;

    logic next_bit;
    assign next_bit = (state == CS_ADDR || state == CS_WBIT) ? shift[WORD_BITS-1] :
                      (state == CS_RACK) ? masterAck : SDA_RELEASE;

    assign cmdReady = state == CS_IDLE;
    assign wrReady = state == CS_WLOAD;
    assign busy = state != CS_IDLE;
    assign sclOut = 1'h0;
    assign sdaOut = 1'h0;
    assign sclOe = sclPull;
    assign sdaOe = sdaPull;

    // Ack toggle from the link domain
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ackMeta <= 1'h0;
            ackSync <= 1'h0;
            ackSeen <= 1'h0;
        end else begin
            ackMeta <= ackTgl;
            ackSync <= ackMeta;
            ackSeen <= ackSync;
        end
    end

    // Request to the link domain; op and bit hold still until the ack returns
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pending <= 1'h0;
            reqTgl <= 1'h0;
            opReq <= OP_IDLECHK;
            bitReq <= SDA_RELEASE;
        end else if (issueNow) begin
            pending <= 1'h1;
            reqTgl <= ~reqTgl;
            opReq <= next_op;
            bitReq <= next_bit;
        end else if (ackPulse) begin
            pending <= 1'h0;
        end
    end

    // Transaction sequencing
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= CS_IDLE;
            shift <= '0;
            bitCnt <= '0;
            remain <= '0;
            readMode <= 1'h0;
            nackSeen <= 1'h0;
            xferDone <= 1'h0;
            xferNack <= 1'h0;
        end else begin
            xferDone <= 1'h0;
            case (state)
                CS_IDLE: begin
                    if (cmdValid) begin
                        shift <= {cmdAddr, cmdRead};
                        bitCnt <= BIT_LAST;
                        remain <= cmdCount;
                        readMode <= cmdRead == DIR_READ;
                        nackSeen <= 1'h0;
                        state <= CS_FREE;
                    end
                end
                CS_FREE: begin
                    if (ackPulse) begin
                        state <= CS_START;
                    end
                end
                CS_START: begin
                    if (ackPulse) begin
                        state <= CS_ADDR;
                    end
                end
                CS_ADDR, CS_WBIT: begin
                    if (ackPulse) begin
                        shift <= {shift[WORD_BITS-2:0], 1'h0};
                        bitCnt <= bitCnt - 3'h1;
                        if (lastBit) begin
                            state <= (state == CS_ADDR) ? CS_AACK : CS_WACK;
                        end
                    end
                end
                CS_AACK: begin
                    if (ackPulse) begin
                        if (!gotAck) begin
                            nackSeen <= 1'h1;
                            state <= CS_STOP;
                        end else if (remain == '0) begin
                            state <= CS_STOP;
                        end else begin
                            state <= readMode ? CS_RWAIT : CS_WLOAD;
                        end
                    end
                end
                CS_WLOAD: begin
                    if (wrValid) begin
                        shift <= wrData;
                        bitCnt <= BIT_LAST;
                        state <= CS_WBIT;
                    end
                end
                CS_WACK: begin
                    if (ackPulse) begin
                        remain <= remain - COUNT_ONE;
                        if (!gotAck) begin
                            nackSeen <= 1'h1;
                            state <= CS_STOP;
                        end else begin
                            state <= lastWord ? CS_STOP : CS_WLOAD;
                        end
                    end
                end
                CS_RWAIT: begin
                    // A full read buffer stalls here with the clock held low
                    if (bufInReady) begin
                        bitCnt <= BIT_LAST;
                        state <= CS_RBIT;
                    end
                end
                CS_RBIT: begin
                    if (ackPulse) begin
                        shift <= rxWord;
                        bitCnt <= bitCnt - 3'h1;
                        if (lastBit) begin
                            state <= CS_RACK;
                        end
                    end
                end
                CS_RACK: begin
                    if (ackPulse) begin
                        remain <= remain - COUNT_ONE;
                        state <= lastWord ? CS_STOP : CS_RWAIT;
                    end
                end
                CS_STOP: begin
                    if (ackPulse) begin
                        xferDone <= 1'h1;
                        xferNack <= nackSeen;
                        state <= CS_IDLE;
                    end
                end
                default: begin
                    state <= CS_IDLE;
                end
            endcase
        end
    end

    // Received words wait here until the user takes them
    tws_fifo #(
        .WIDTH(WORD_BITS),
        .DEPTH(DEPTH)
    ) readBuf (
        .clk(clk),
        .reset_n(reset_n),
        .inValid(pushWord),
        .inReady(bufInReady),
        .inData(rxWord),
        .outValid(rdValid),
        .outReady(rdReady),
        .outData(rdData)
    );

    // Link domain: request toggle and pin synchronisers
    always_ff @(posedge linkClk or negedge reset_n) begin
        if (!reset_n) begin
            reqMeta <= 1'h0;
            reqSync <= 1'h0;
            reqSeen <= 1'h0;
            sclMeta <= 1'h1;
            sclSync <= 1'h1;
            sdaMeta <= 1'h1;
            sdaSync <= 1'h1;
        end else begin
            reqMeta <= reqTgl;
            reqSync <= reqMeta;
            reqSeen <= reqSync;
            sclMeta <= sclIn;
            sclSync <= sclMeta;
            sdaMeta <= sdaIn;
            sdaSync <= sdaMeta;
        end
    end

    wire reqPulse = reqSync ^ reqSeen;
    wire tickLast = tick == TICK_LAST;
    wire busFree = sclSync && sdaSync;
    // Released clock still low: a target stretching it, or the edge not yet seen
    wire stretch = !sclPull && !sclSync;
    wire isStart = lkOp == OP_START;
    wire isBit = lkOp == OP_BIT;
    wire isStop = lkOp == OP_STOP;

    // Line pulls per phase; in a bit op data only moves while the clock is held low, START and STOP move it with the clock high
    wire phaseScl = isStart ? (phase == PHASE_LAST) :
                    isBit ? (phase == PHASE_FIRST || phase == PHASE_LAST) :
                    isStop ? (phase == PHASE_FIRST) : 1'h0;
    wire phaseSda = isStart ? phase[1] :
                    isBit ? (lkBit != SDA_RELEASE) :
                    isStop ? !phase[1] : 1'h0;

    // Link domain: one bit operation, four quarter periods
    always_ff @(posedge linkClk or negedge reset_n) begin
        if (!reset_n) begin
            running <= 1'h0;
            lkOp <= OP_IDLECHK;
            lkBit <= SDA_RELEASE;
            phase <= PHASE_FIRST;
            tick <= '0;
            ackTgl <= 1'h0;
            rxBit <= SDA_RELEASE;
        end else if (reqPulse) begin
            running <= 1'h1;
            lkOp <= opReq;
            lkBit <= bitReq;
            phase <= PHASE_FIRST;
            tick <= '0;
        end else if (running) begin
            if (lkOp == OP_IDLECHK && !busFree) begin
                tick <= '0;
                phase <= PHASE_FIRST;
            end else if (stretch) begin
                tick <= tick;
            end else if (!tickLast) begin
                tick <= tick + TICK_W'(1);
            end else begin
                tick <= '0;
                phase <= phase + 2'h1;
                if (phase == PHASE_SAMPLE) begin
                    rxBit <= sdaSync;
                end
                if (phase == PHASE_LAST) begin
                    running <= 1'h0;
                    ackTgl <= ~ackTgl;
                end
            end
        end
    end

    // Line drivers hold their last level between operations
    always_ff @(posedge linkClk or negedge reset_n) begin
        if (!reset_n) begin
            sclPull <= 1'h0;
            sdaPull <= 1'h0;
        end else if (running) begin
            sclPull <= phaseScl;
            sdaPull <= phaseSda;
        end
    end

endmodule : tws_sequencer

// file: tb/tws_sequencer_assertions.sv
`timescale 1ns/1ps

module tws_sequencer_assertions (
    // System side
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cmdValid,
    input wire logic cmdReady,
    input wire logic rdValid,
    input wire logic rdReady,
    input wire logic [7:0] rdData,
    input wire logic busy,
    input wire logic xferDone,
    input wire logic xferNack,
    // Link side
    input wire logic linkClk,
    input wire logic sclOe,
    input wire logic sdaOe
);
    a_accept_busy: assert property (@(posedge clk) disable iff (!reset_n)
        cmdValid && cmdReady |=> busy && !cmdReady) else $error("busy late");
    a_done_idle: assert property (@(posedge clk) disable iff (!reset_n)
        xferDone |=> cmdReady && !busy && !xferDone) else $error("not idle after done");
    a_idle_free: assert property (@(posedge clk) disable iff (!reset_n)
        !busy |-> !sclOe && !sdaOe) else $error("line pulled while idle");
    a_nack_done: assert property (@(posedge clk) disable iff (!reset_n)
        $changed(xferNack) |-> xferDone) else $error("nack moved alone");
    a_read_held: assert property (@(posedge clk) disable iff (!reset_n)
        rdValid && !rdReady |=> rdValid && $stable(rdData)) else $error("read word lost");
    a_sda_steady: assert property (@(posedge linkClk) disable iff (!reset_n)
        $fell(sclOe) |-> $stable(sdaOe)) else $error("data moved at clock rise");
    a_scl_high: assert property (@(posedge linkClk) disable iff (!reset_n)
        $fell(sclOe) |-> !sclOe [*8]) else $error("clock high too short");
    a_start_clock: assert property (@(posedge linkClk) disable iff (!reset_n)
        $rose(sdaOe) && !sclOe |-> ##[1:40] sclOe) else $error("no clock after start");
endmodule : tws_sequencer_assertions

bind tws_sequencer tws_sequencer_assertions u_chk (.*);

// file: tb/tws_target_model.sv
`timescale 1ns/1ps

module tws_target_model
    import tws_pkg::*;
(
    // Bus wires
    input wire logic sclW,
    input wire logic sdaW,
    // Settings
    input wire logic [ADDR_BITS-1:0] ownAddr,
    input wire logic [7:0] nackWord,
    // Pull on data
    output logic sdaPull,
    // Last word written; count of words written, or of read words the master acknowledged
    output logic [7:0] rxWord,
    output logic [7:0] rxCount
);
    logic [7:0] sh;
    logic [7:0] rw;
    int idx;

    task getByte;
        repeat (8) @(posedge sclW) sh = {sh[6:0], sdaW};
    endtask : getByte

    // Abandon any transfer at STOP, as a real target would
    always @(posedge sdaW) begin
        if (sclW === 1'b1) begin
            sdaPull <= 1'b0;
            disable eng.xfer;
        end
    end

    initial begin : eng
        sdaPull <= 1'b0;
        forever begin : xfer
            @(negedge sdaW iff sclW === 1'b1);
            rxCount = 8'h00;
            idx = 0;
            getByte;
            if (sh[7:1] === ownAddr) begin
                @(negedge sclW) sdaPull <= 1'b1;
                while (sh[0] === DIR_READ) begin
                    rw = 8'ha5 ^ 8'(idx);
                    for (int i = 7; i >= 0; i--) @(negedge sclW) sdaPull <= !rw[i];
                    @(negedge sclW) sdaPull <= 1'b0;
                    // Stay off the line after a refusal so the STOP can pass
                    @(posedge sclW) if (sdaW !== ACK_LEVEL) wait (1'b0);
                    idx++;
                    rxCount++;
                end
                forever begin
                    @(negedge sclW) sdaPull <= 1'b0;
                    getByte;
                    rxWord = sh;
                    rxCount++;
                    @(negedge sclW) sdaPull <= 8'(idx) != nackWord;
                    idx++;
                end
            end
        end
    end
endmodule : tws_target_model

// file: tb/tws_sequencer_tb.sv
`timescale 1ns/1ps

module tws_sequencer_tb;
    logic clk = 1'b0;
    logic linkClk = 1'b0;
    logic reset_n = 1'b0;
    logic cmdValid = 1'b0;
    logic cmdRead = 1'b0;
    logic wrValid = 1'b0;
    logic rdReady = 1'b0;
    logic holdScl = 1'b0;
    logic [6:0] cmdAddr = 7'h00;
    logic [15:0] cmdCount = 16'h0000;
    logic [7:0] wrData = 8'h00;
    logic [7:0] nackWord = 8'hff;
    logic cmdReady, wrReady, rdValid, busy, xferDone, xferNack, sclOe, sdaOe, tgtPull, nack;
    logic [7:0] rdData, rxWord, rxCount;
    logic sclOut, sdaOut;
    wire logic sclW = !(sclOe || holdScl);
    wire logic sdaW = !(sdaOe || tgtPull);
    int err_total = 0;
    int n_compared = 0;
    int nw;
    int nr;

    initial forever #12.5 clk = ~clk;
    initial #1.7 forever #3 linkClk = ~linkClk;

    tws_sequencer #(.QUARTER(4)) dut (.sclIn(sclW), .sdaIn(sdaW), .*);
    tws_target_model tgt (.ownAddr(7'h2a), .sdaPull(tgtPull), .*);

    function automatic logic [7:0] word(input int n);
        return 8'h3c + 8'(n * 37);
    endfunction : word

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic runXfer(input logic [6:0] a, input logic rd, input int cnt, hold, stall);
        logic done, tw, tr;
        done = 1'b0;
        nw = 0;
        nr = 0;
        @(posedge clk);
        cmdAddr <= a;
        cmdRead <= rd;
        cmdCount <= 16'(cnt);
        cmdValid <= 1'b1;
        wrValid <= !rd && cnt > 0;
        wrData <= word(0);
        holdScl <= hold > 0;
        for (int t = 0; t < 20000 && !done; t++) begin
            @(negedge clk);
            done = xferDone === 1'b1;
            nack = xferNack;
            tw = (wrValid && wrReady) === 1'b1;
            tr = (rdValid && rdReady) === 1'b1;
            if (t < hold) check({sclOe, sdaOe}, 2'h0);
            if (tr) check(rdData, 8'ha5 ^ 8'(nr));
            @(posedge clk);
            cmdValid <= 1'b0;
            holdScl <= t + 1 < hold;
            rdReady <= t >= stall;
            nw += tw;
            nr += tr;
            wrData <= word(nw);
        end
        wrValid <= 1'b0;
        rdReady <= 1'b0;
        check(done, 1'b1);
    endtask : runXfer

    task automatic t_reset;
        @(negedge clk);
        check({cmdReady, busy, wrReady, rdValid, xferDone, xferNack, sclOe, sdaOe}, 8'h80);
        check({sclOut, sdaOut}, 2'h0);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_free;
        runXfer(7'h2a, 1'b0, 0, 300, 0);
        check(nack, 1'b0);
        $display("t_free done");
    endtask : t_free

    task automatic t_write;
        runXfer(7'h2a, 1'b0, 3, 0, 0);
        check(nack, 1'b0);
        check(nw, 3);
        check(rxCount, 3);
        check(rxWord, word(2));
        $display("t_write done");
    endtask : t_write

    task automatic t_badaddr;
        runXfer(7'h2b, 1'b0, 2, 0, 0);
        check(nack, 1'b1);
        check(nw, 0);
        $display("t_badaddr done");
    endtask : t_badaddr

    task automatic t_wnack;
        nackWord <= 8'h00;
        runXfer(7'h2a, 1'b0, 3, 0, 0);
        nackWord <= 8'hff;
        check(nack, 1'b1);
        check(nw, 1);
        check(rxCount, 1);
        $display("t_wnack done");
    endtask : t_wnack

    task automatic t_read;
        // Reader stalls long enough for the buffer to fill and hold the bus
        runXfer(7'h2a, 1'b1, 3, 0, 1000);
        check(nack, 1'b0);
        check(nr, 3);
        check(rxCount, 2);
        $display("t_read done");
    endtask : t_read

    task automatic stop_test;
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    initial begin
        t_reset;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        t_free;
        t_write;
        t_badaddr;
        t_wnack;
        t_read;
        stop_test;
    end

    initial begin
        #1000000;
        err_total++;
        stop_test;
    end
endmodule : tws_sequencer_tb
